// ---- hw/pll_core_map.svh ----
// pll_core_map.svh: offsets, field positions, reset values and counts
// of the synthesiser control core; included by the pll_core module and its test.
`ifndef PLL_CORE_MAP_SVH
`define PLL_CORE_MAP_SVH

// serial word
`define SR_W              24
`define SR_ADDR_HI_BIT    1
`define SR_ADDR_LO_BIT    0
`define SR_PAYLOAD_LSB    2

// prescaler base ratios
`define BASE_N_HI         5'h10
`define BASE_N_LO         5'h08
`define SWALLOW_MASK_DIV8 4'h7

// reset contents of the buffers and the control register
`define FREQ_RST          22'h00_0000
`define REF_RST           16'h0001
`define SWALLOW_RST       4'h0
`define CTRL_RST          32'h0000_0000

// register byte offsets
`define OFF_CTRL          8'h00
`define OFF_STATUS        8'h04
`define OFF_FREQ_ONE      8'h08
`define OFF_FREQ_TWO      8'h0c
`define OFF_REF           8'h10
`define OFF_SWALLOW       8'h14

// control and status bits
`define CTRL_PWRDN_BIT    0
`define STAT_SEL_ONE_BIT  0
`define STAT_LOCK_BIT     1
`define STAT_DIV8_BIT     2
`define STAT_SW_OVR_BIT   3

// bus answers
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ---- hw/pll_core_pkg.sv ----
// pll_core_pkg: word layouts and buffer addresses of the synthesiser core.
// assumes pll_core_map.svh for the numeric constants.
package pll_core_pkg;

    typedef struct packed {
        logic        sense;
        logic        gain_sel_hi;
        logic        gain_sel_lo;
        logic [14:0] main_ratio;
        logic [3:0]  swallow_bits;
    } freq_word_t;

    typedef struct packed {
        logic        presc_div8;
        logic        det_enable_hi;
        logic        det_enable_lo;
        logic [12:0] ref_ratio;
    } ref_word_t;

    typedef enum logic [1:0] {
        BUF_FREQ_ONE = 2'h0,
        BUF_SWALLOW  = 2'h1,
        BUF_FREQ_TWO = 2'h2,
        BUF_REF      = 2'h3
    } buf_addr_t;

endpackage

// ---- hw/prog_divider.sv ----
// prog_divider: programmable divide-by-ratio counter on a tick enable.
// assumes tick is a one-cycle pulse in the core_clk domain.
`timescale 1ns/1ps
`default_nettype none
module prog_divider #(
    parameter int W = 15
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst,
    // count
    input  wire logic         tick,
    input  wire logic [W-1:0] ratio,
    output logic              wrap
);
    logic [W-1:0] count_q;

    // ratio is sampled at each wrap, so a new value acts from the next wrap
    assign wrap = tick && (count_q == '0);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            count_q <= '0;
        end else if (wrap) begin
            count_q <= (ratio == '0) ? '0 : W'(ratio - 1'b1);
        end else if (tick) begin
            count_q <= W'(count_q - 1'b1);
        end
    end
endmodule // prog_divider
`default_nettype wire

// ---- hw/pll_core.sv ----
// pll_core: digital control core of a PLL synthesiser: divider chain,
// reference divider, detector option logic, three-wire load, AXI4-Lite view.
// assumes all pins asynchronous to core_clk; rf and ref pins slower than core_clk/4.
// Function
// R1: divider chain ratio is M times N plus A
// R2: static 16/17 or 8/9 from reference bit
// R3: four-bit swallow counter, starts each main cycle
// R4: prescaler N+1 while swallowing, then N
// R5: main counter is fifteen bits wide
// R6: counters reload from active word each cycle
// R7: 8/9 mode uses three swallow bits only
// R8: thirteen-bit reference divider, ratio 1 to 8191
// R9: gain bits select pump currents and multiplier
// R10: lock window drives lock low, gates pump one
// R11: comparison outputs routed only when enabled
// R12: sense bit swaps detector inputs and outputs
// R13: 24-bit shift register, MSB first
// R14: enable fall loads buffer chosen by last bits
// R15: controller puts address bits last, drops enable
// R16: frequency buffers hold 22 bits
// R17: reference buffer holds 16 bits
// R18: buffers keep control while shifting new data
// R19: select pin high picks frequency one
// R20: controller sends 24 or 18 bit words
// R21: controller zeroes unused bit in 8/9 mode
// R22: shift register and buffers writable in power-down
// R23: detector-enable bits set outputs and pump one
// R24: data sampled on serial clock rise, enable high
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pll_core_map.svh"
module pll_core #(
    parameter int ADDR_W = 8,
    parameter int MAIN_W = 15,
    parameter int REF_W  = 13
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // rf and reference inputs
    input  wire logic              rf_in,
    input  wire logic              ref_in,
    // three-wire programming bus and select
    input  wire logic              ser_clk,
    input  wire logic              ser_data,
    input  wire logic              ser_en,
    input  wire logic              freq_word_select,
    // lock window comparator on pump two
    input  wire logic              pump_two_in_window,
    // divider and detector outputs
    output logic                   divided_rf_out,
    output logic                   ref_div_out,
    output logic                   det_in_a,
    output logic                   det_in_b,
    output logic                   cmp_out_one,
    output logic                   cmp_out_two,
    output logic                   presc_mod_plus,
    // charge pump control
    output logic [1:0]             pump_gain_sel,
    output logic                   pump_sink,
    output logic                   pump_one_enable,
    output logic                   pump_two_enable,
    output logic                   lock_detect_n,
    // axi4-lite write
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);
    localparam int NPIN = 7;

    // pin synchronisers
    logic [NPIN-1:0] pin_meta_q;
    logic [NPIN-1:0] pin_q;
    logic [NPIN-1:0] pin_prev_q;
    logic            rf_s, ref_s, sclk_s, sdata_s, sen_s, sel_s, win_s;
    logic            rf_rise, ref_rise, sclk_rise, sen_fall;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_meta_q <= '0;
            pin_q      <= '0;
            pin_prev_q <= '0;
        end else begin
            pin_meta_q <= {pump_two_in_window, freq_word_select, ser_en, ser_data, ser_clk, ref_in, rf_in};
            pin_q      <= pin_meta_q;
            pin_prev_q <= pin_q;
        end
    end

    assign {win_s, sel_s, sen_s, sdata_s, sclk_s, ref_s, rf_s} = pin_q;
    assign rf_rise   = rf_s && !pin_prev_q[0];
    assign ref_rise  = ref_s && !pin_prev_q[1];
    assign sclk_rise = sclk_s && !pin_prev_q[2];
    assign sen_fall  = !sen_s && pin_prev_q[4];

    // serial shift register
    logic [`SR_W-1:0] shift_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            shift_q <= '0;
        end else if (sclk_rise && sen_s) begin
            shift_q <= {shift_q[`SR_W-2:0], sdata_s};  // [R13] [R24]
        end
    end

    // buffers, loaded on enable fall; independent of power-down [R22]
    pll_core_pkg::freq_word_t freq_one_q, freq_two_q, freq_load;
    pll_core_pkg::ref_word_t  ref_q, ref_load;
    pll_core_pkg::buf_addr_t  load_addr;
    logic [3:0]               swallow_q;
    logic                     swallow_ovr_q;

    assign load_addr = pll_core_pkg::buf_addr_t'({shift_q[`SR_ADDR_HI_BIT], shift_q[`SR_ADDR_LO_BIT]});
    assign freq_load = pll_core_pkg::freq_word_t'(shift_q[`SR_W-1:`SR_PAYLOAD_LSB]);  // [R16]
    assign ref_load  = pll_core_pkg::ref_word_t'(shift_q[`SR_PAYLOAD_LSB+15:`SR_PAYLOAD_LSB]);  // [R17]

    always_ff @(posedge core_clk) begin
        if (rst) begin
            freq_one_q <= `FREQ_RST;
            freq_two_q <= `FREQ_RST;
        end else if (sen_fall && load_addr == pll_core_pkg::BUF_FREQ_ONE) begin
            freq_one_q <= freq_load;  // [R14] [R18]
        end else if (sen_fall && load_addr == pll_core_pkg::BUF_FREQ_TWO) begin
            freq_two_q <= freq_load;  // [R14] [R18]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ref_q <= `REF_RST;
        end else if (sen_fall && load_addr == pll_core_pkg::BUF_REF) begin
            ref_q <= ref_load;  // [R14]
        end
    end

    // swallow buffer overrides the active word's swallow bits until a frequency load
    always_ff @(posedge core_clk) begin
        if (rst) begin
            swallow_q     <= `SWALLOW_RST;
            swallow_ovr_q <= 1'b0;
        end else if (sen_fall && load_addr == pll_core_pkg::BUF_SWALLOW) begin
            swallow_q     <= shift_q[`SR_PAYLOAD_LSB+3:`SR_PAYLOAD_LSB];  // [R14]
            swallow_ovr_q <= 1'b1;
        end else if (sen_fall && !load_addr[0]) begin
            swallow_ovr_q <= 1'b0;
        end
    end

    // active word
    pll_core_pkg::freq_word_t act;
    logic [3:0]               swallow_raw;
    logic [3:0]               swallow_eff;

    assign act         = sel_s ? freq_one_q : freq_two_q;  // [R19]
    assign swallow_raw = swallow_ovr_q ? swallow_q : act.swallow_bits;
    assign swallow_eff = ref_q.presc_div8 ? (swallow_raw & `SWALLOW_MASK_DIV8) : swallow_raw;  // [R7]

    // divider chain: prescaler, swallow counter, main counter
    logic [4:0]        presc_ratio;
    logic              presc_wrap;
    logic              main_wrap;
    logic [3:0]        swallow_cnt_q;
    logic [3:0]        swallow_cnt_d;

    always_comb begin
        swallow_cnt_d = swallow_cnt_q;
        if (main_wrap) begin
            swallow_cnt_d = swallow_eff;  // [R3] [R6]
        end else if (presc_wrap && swallow_cnt_q != 4'h0) begin
            swallow_cnt_d = swallow_cnt_q - 4'h1;  // [R3]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            swallow_cnt_q <= 4'h0;
        end else begin
            swallow_cnt_q <= swallow_cnt_d;
        end
    end

    // next prescaler cycle runs at N+1 while swallows remain [R4]
    assign presc_ratio = (ref_q.presc_div8 ? `BASE_N_LO : `BASE_N_HI)  // [R2]
                         + {4'h0, swallow_cnt_d != 4'h0};  // [R1] [R4]

    prog_divider #(
        .W (5)
    ) u_presc (
        .core_clk (core_clk),
        .rst      (rst),
        .tick     (rf_rise),
        .ratio    (presc_ratio),
        .wrap     (presc_wrap)
    );

    prog_divider #(
        .W (MAIN_W)
    ) u_main (
        .core_clk (core_clk),
        .rst      (rst),
        .tick     (presc_wrap),
        .ratio    (act.main_ratio),  // [R5] [R6]
        .wrap     (main_wrap)
    );

    // reference divider, ratio 0 behaves as 1
    logic ref_wrap;

    prog_divider #(
        .W (REF_W)
    ) u_ref (
        .core_clk (core_clk),
        .rst      (rst),
        .tick     (ref_rise),
        .ratio    (ref_q.ref_ratio),  // [R8]
        .wrap     (ref_wrap)
    );

    // divided outputs toggle once per divider cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            divided_rf_out <= 1'b0;
            ref_div_out    <= 1'b0;
            presc_mod_plus <= 1'b0;
        end else begin
            divided_rf_out <= divided_rf_out ^ main_wrap;  // [R1]
            ref_div_out    <= ref_div_out ^ ref_wrap;  // [R8]
            presc_mod_plus <= swallow_cnt_d != 4'h0;  // [R4]
        end
    end

    // detector routing and pump control
    logic ctrl_pwrdn;
    logic outs_on;
    logic pump_one_on;

    assign outs_on = ref_q.det_enable_hi && !ctrl_pwrdn;  // [R11] [R23]

    always_comb begin
        case ({ref_q.det_enable_hi, ref_q.det_enable_lo})
            2'h0:    pump_one_on = 1'b1;  // [R23]
            2'h2:    pump_one_on = 1'b0;  // [R23]
            default: pump_one_on = !win_s;  // [R10] [R23]
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            det_in_a        <= 1'b0;
            det_in_b        <= 1'b0;
            cmp_out_one     <= 1'b0;
            cmp_out_two     <= 1'b0;
            pump_gain_sel   <= 2'h0;
            pump_sink       <= 1'b0;
            pump_one_enable <= 1'b0;
            pump_two_enable <= 1'b0;
            lock_detect_n   <= 1'b1;
        end else begin
            det_in_a        <= act.sense ? ref_div_out : divided_rf_out;  // [R12]
            det_in_b        <= act.sense ? divided_rf_out : ref_div_out;  // [R12]
            cmp_out_one     <= outs_on && (act.sense ? ref_div_out : divided_rf_out);  // [R11] [R12]
            cmp_out_two     <= outs_on && (act.sense ? divided_rf_out : ref_div_out);  // [R11] [R12]
            pump_gain_sel   <= {act.gain_sel_hi, act.gain_sel_lo};  // [R9]
            pump_sink       <= act.sense;  // [R12]
            pump_one_enable <= pump_one_on && !ctrl_pwrdn;  // [R10]
            pump_two_enable <= !ctrl_pwrdn;  // [R23]
            lock_detect_n   <= !win_s;  // [R10]
        end
    end

    // axi4-lite slave: one write and one read in flight
    logic [31:0]       ctrl_q;
    logic              aw_have_q, w_have_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;
    logic              wr_go;

    assign ctrl_pwrdn    = ctrl_q[`CTRL_PWRDN_BIT];
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
    assign wr_go         = aw_have_q && w_have_q && !s_axi_bvalid;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            w_have_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_go) begin
            w_have_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_q <= `CTRL_RST;
        end else if (wr_go && aw_addr_q == ADDR_W'(`OFF_CTRL) && w_strb_q[0]) begin
            ctrl_q <= {31'h0, w_data_q[`CTRL_PWRDN_BIT]};
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_q == ADDR_W'(`OFF_CTRL)) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read path
    logic [31:0] rd_word;
    logic        rd_hit;
    logic [31:0] status_word;

    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        status_word                    = 32'h0000_0000;
        status_word[`STAT_SEL_ONE_BIT] = sel_s;
        status_word[`STAT_LOCK_BIT]    = win_s;
        status_word[`STAT_DIV8_BIT]    = ref_q.presc_div8;
        status_word[`STAT_SW_OVR_BIT]  = swallow_ovr_q;
    end

    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        case (s_axi_araddr)
            ADDR_W'(`OFF_CTRL):     rd_word = ctrl_q;
            ADDR_W'(`OFF_STATUS):   rd_word = status_word;
            ADDR_W'(`OFF_FREQ_ONE): rd_word = {10'h000, freq_one_q};
            ADDR_W'(`OFF_FREQ_TWO): rd_word = {10'h000, freq_two_q};
            ADDR_W'(`OFF_REF):      rd_word = {16'h0000, ref_q};
            ADDR_W'(`OFF_SWALLOW):  rd_word = {28'h000_0000, swallow_q};
            default:                rd_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // pll_core
`default_nettype wire

// ---- testbench/pll_core_assertions.sv ----
// pll_core_assertions: port-level checks on pll_core, bound below.
// assumes one core_clk domain, rst synchronous active high.
`timescale 1ns/1ps
`default_nettype none
module pll_core_assertions (
    // clock and reset
    input wire logic        core_clk, rst,
    // pins
    input wire logic        pump_two_in_window, lock_detect_n, pump_sink,
    input wire logic        pump_one_enable, pump_two_enable,
    input wire logic        divided_rf_out, ref_div_out, det_in_a, det_in_b,
    // bus
    input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
    input wire logic        s_axi_rvalid, s_axi_rready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic [31:0] s_axi_rdata
);
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (rst);

    a_lock_in_win: assert property (pump_two_in_window [*6] |-> !lock_detect_n)
        else $error("lock flag high in window");
    a_lock_out_win: assert property ((!pump_two_in_window) [*6] |-> lock_detect_n)
        else $error("lock flag low out of window");
    a_sense_plain: assert property ((!pump_sink) [*2] |->
        det_in_a == $past(divided_rf_out) && det_in_b == $past(ref_div_out))
        else $error("detector inputs swapped");
    a_pump_pair: assert property (pump_one_enable |-> pump_two_enable)
        else $error("pump one on while pump two off");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");

    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_lock: cover property ($fell(lock_detect_n));
endmodule // pll_core_assertions

bind pll_core pll_core_assertions u_pll_core_assertions (
    .core_clk(core_clk), .rst(rst), .pump_two_in_window(pump_two_in_window),
    .lock_detect_n(lock_detect_n), .pump_sink(pump_sink), .pump_one_enable(pump_one_enable),
    .pump_two_enable(pump_two_enable), .divided_rf_out(divided_rf_out), .ref_div_out(ref_div_out),
    .det_in_a(det_in_a), .det_in_b(det_in_b), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_bresp(s_axi_bresp), .s_axi_rdata(s_axi_rdata)
);
`default_nettype wire

// ---- testbench/pll_host_model.sv ----
// pll_host_model: controller driving the three-wire load pins.
// assumes core_clk paces it; serial clock period 160 ns.
`timescale 1ns/1ps
`default_nettype none
module pll_host_model (
    input wire logic core_clk,
    output logic     ser_clk,
    output logic     ser_data,
    output logic     ser_en
);
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_en = 1'b0;
    end
    // msb first, address bits last, clock still outside frames
    task automatic send(input logic [23:0] w, input int n);
        int i;
        ser_en <= 1'b1;
        for (i = n - 1; i >= 0; i--) begin
            ser_data <= w[i];
            repeat (8) @(posedge core_clk);
            ser_clk <= 1'b1;
            repeat (8) @(posedge core_clk);
            ser_clk <= 1'b0;
        end
        repeat (8) @(posedge core_clk);
        ser_en <= 1'b0;
        ser_data <= ~w[0];
        repeat (8) @(posedge core_clk);
    endtask
endmodule // pll_host_model
`default_nettype wire

// ---- testbench/pll_core_test.sv ----
// pll_core_test: serial load, bus and divider checks.
// assumes pll_host_model drives the serial pins.
`timescale 1ns/1ps
`default_nettype none
`include "pll_core_map.svh"
module pll_core_test;
    logic        core_clk = 0, rst = 1, osc = 0, fws = 0, win = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [1:0]  bresp, rresp, pump_gain_sel;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, ser_clk, ser_data, ser_en;
    logic        divided_rf_out, ref_div_out, cmp_out_one, cmp_out_two;
    logic        pump_sink, pump_one_enable, pump_two_enable, lock_detect_n, mod_plus;
    int          bad_count = 0, comparisons = 0;

    pll_core u_pll_core (
        .core_clk(core_clk), .rst(rst), .rf_in(osc), .ref_in(osc), .ser_clk(ser_clk),
        .ser_data(ser_data), .ser_en(ser_en), .freq_word_select(fws), .pump_two_in_window(win),
        .divided_rf_out(divided_rf_out), .ref_div_out(ref_div_out), .det_in_a(), .det_in_b(),
        .cmp_out_one(cmp_out_one), .cmp_out_two(cmp_out_two), .presc_mod_plus(mod_plus),
        .pump_gain_sel(pump_gain_sel), .pump_sink(pump_sink), .pump_one_enable(pump_one_enable),
        .pump_two_enable(pump_two_enable), .lock_detect_n(lock_detect_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready)
    );
    pll_host_model u_pll_host_model (.core_clk(core_clk), .ser_clk(ser_clk), .ser_data(ser_data),
        .ser_en(ser_en));

    always #5 core_clk = ~core_clk;
    // rf and ref pins share one square wave
    always begin
        repeat (4) @(posedge core_clk);
        osc <= ~osc;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_t, w_t, b_t, v;
        int n;
        b_t = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 64 && !b_t; n++) begin
            @(negedge core_clk);
            aw_t = awvalid & awready;
            w_t = wvalid & wready;
            v = bvalid;
            b_t = v & bready;
            r = bresp;
            @(posedge core_clk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
            bready <= !b_t;
        end
        chk(32'(b_t), 1);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic a_t, v_t, v;
        logic [31:0] d;
        logic [1:0] r;
        int n;
        v_t = 0;
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 64 && !v_t; n++) begin
            @(negedge core_clk);
            a_t = arvalid & arready;
            v = rvalid;
            v_t = v & rready;
            d = rdata;
            r = rresp;
            @(posedge core_clk);
            if (a_t) arvalid <= 1'b0;
            rready <= !v_t;
        end
        chk(d, e);
        chk(32'(r), 32'(er));
    endtask

    // osc rises between two later toggles of a divider
    task automatic meas(input logic sel, output int cnt);
        logic o, cur, lo;
        int k, t;
        t = 0;
        cnt = 0;
        @(negedge core_clk);
        o = sel ? ref_div_out : divided_rf_out;
        lo = osc;
        for (k = 0; k < 8000 && t < 3; k++) begin
            @(negedge core_clk);
            cur = sel ? ref_div_out : divided_rf_out;
            if (osc && !lo) cnt++;
            if (cur !== o) t++;
            if (cur !== o && t == 2) cnt = 0;
            o = cur;
            lo = osc;
        end
        @(posedge core_clk);
    endtask
    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge core_clk);
        bad_count++;
        report_and_stop();
    end

    initial begin
        pll_core_pkg::freq_word_t fa, fb;
        logic [1:0] r;
        logic s;
        int c, g, m, w;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        rchk(`OFF_CTRL, 32'h0, `RESP_OKAY);
        rchk(`OFF_FREQ_ONE, 32'h0, `RESP_OKAY);
        rchk(`OFF_REF, 32'h1, `RESP_OKAY);
        rchk(`OFF_SWALLOW, 32'h0, `RESP_OKAY);
        chk(32'(mod_plus), 0);
        rchk(8'h18, 32'h0, `RESP_SLVERR);
        wr(`OFF_STATUS, 32'h1, r);
        chk(32'(r), `RESP_SLVERR);
        meas(1'b1, c);
        chk(c, 1);
        fws <= 1'b1;
        for (g = 0; g < 4; g++) begin
            fa = {1'b0, g[1], g[0], 15'd3, 4'd2};
            u_pll_host_model.send({fa, pll_core_pkg::BUF_FREQ_ONE}, 24);
            chk(32'(pump_gain_sel), g);
        end
        rchk(`OFF_FREQ_ONE, 32'(fa), `RESP_OKAY);
        rchk(`OFF_STATUS, 32'h1, `RESP_OKAY);
        fb = {1'b1, 1'b0, 1'b1, 15'd10, 4'd5};
        u_pll_host_model.send({fb, pll_core_pkg::BUF_FREQ_TWO}, 24);
        rchk(`OFF_FREQ_TWO, 32'(fb), `RESP_OKAY);
        meas(1'b0, c);
        chk(c, 3 * `BASE_N_HI + 2);
        fws <= 1'b0;
        meas(1'b0, c);
        chk(c, 10 * `BASE_N_HI + 5);
        chk(32'(pump_sink), 1);
        chk(32'(pump_gain_sel), 1);
        u_pll_host_model.send({18'h0, 4'h9, pll_core_pkg::BUF_SWALLOW}, 24);
        rchk(`OFF_SWALLOW, 32'h9, `RESP_OKAY);
        meas(1'b0, c);
        chk(c, 10 * `BASE_N_HI + 9);
        u_pll_host_model.send({6'h0, 1'b1, 2'b00, 13'd5, pll_core_pkg::BUF_REF}, 18);
        rchk(`OFF_REF, {16'h0, 1'b1, 2'b00, 13'd5}, `RESP_OKAY);
        u_pll_host_model.send({fb, pll_core_pkg::BUF_FREQ_TWO}, 24);
        meas(1'b0, c);
        chk(c, 10 * `BASE_N_LO + 5);
        meas(1'b1, c);
        chk(c, 5);
        for (m = 0; m < 4; m++) begin
            u_pll_host_model.send({6'h0, 1'b0, m[1], m[0], 13'd5, pll_core_pkg::BUF_REF}, 18);
            for (w = 0; w < 2; w++) begin
                win <= w[0];
                repeat (8) @(posedge core_clk);
                chk(32'(pump_one_enable), (m == 0) ? 1 : (m == 2) ? 0 : 1 - w);
                chk(32'(lock_detect_n), 1 - w);
                chk(32'(pump_two_enable), 1);
            end
            s = 1'b0;
            repeat (100) @(posedge core_clk) s = s | cmp_out_one | cmp_out_two;
            chk(32'(s), m / 2);
        end
        win <= 1'b0;
        wr(`OFF_CTRL, 32'h1, r);
        repeat (8) @(posedge core_clk);
        chk(32'(pump_two_enable), 0);
        chk(32'(pump_one_enable), 0);
        u_pll_host_model.send({fa, pll_core_pkg::BUF_FREQ_TWO}, 24);
        rchk(`OFF_FREQ_TWO, 32'(fa), `RESP_OKAY);
        wr(`OFF_CTRL, 32'h0, r);
        chk(32'(r), `RESP_OKAY);
        report_and_stop();
    end
endmodule // pll_core_test
`default_nettype wire
